// ==== rtl/dwl_host.v ====
`timescale 1ns/1ps
`include "dwl_consts.vh"
// What this block does
// - Dynamic write termination must already be off in mr1Base; it is not cleared here.
// - Only deselects and output-disable or exit mode writes during leveling.
// - Levels a single rank; no output disable word is sent to other ranks.
// - Raise termination only after mode set delay, plus on-latency if raised.
// - After strobe enable delay drive true strobe low, complement high.
// - After strobe low time and first strobe delay, send one strobe pulse.
// - Sample feedback, step delay, repeat until 0-to-1 change, then lock.
// - Strobe enable delay exceeds mode set plus termination on times.
// - Strobe pulses meet minimum high and low widths.
// - Exit: stop strobes, termination low, clear level bit, wait delays.
module dwl_host (
   // clock and reset
   input  wire                  clk_sys,
   input  wire                  rst_n,
   // user side
   input  wire                  start,
   input  wire [15:0]           mr1Base,
   input  wire                  latRaised,
   input  wire [`DWL_CNT_W-1:0] termOnLat,
   output wire                  busy,
   output reg                   done,
   output reg                   failed,
   output reg  [`DWL_TAP_W-1:0] lockTapLo,
   output reg  [`DWL_TAP_W-1:0] lockTapHi,
   // mode register write port toward the device
   output reg                   mrsValid,
   output reg  [15:0]           mrsData,
   // termination control pin
   output reg                   termPin,
   // strobes, per lane
   output reg  [1:0]            dqsT,
   output reg  [1:0]            dqsC,
   output reg  [1:0]            dqsOe,
   output reg  [`DWL_TAP_W-1:0] dqsDelayLo,
   output reg  [`DWL_TAP_W-1:0] dqsDelayHi,
   // feedback, one bit sampled per lane
   input  wire [1:0]            dqFeedback
);
   localparam integer MODE_SET  = `DWL_CYC(`DWL_MODE_SET_NS);
   localparam integer MRW_CYC   = `DWL_CYC(`DWL_MRW_CYCLE_NS);
   localparam integer DQS_EN    = `DWL_CYC(`DWL_DQS_EN_NS);
   localparam integer FIRST_DQS = `DWL_CYC(`DWL_FIRST_DQS_NS);
   localparam integer DQS_LOW   = `DWL_CYC(`DWL_DQS_LOW_NS);
   localparam integer DQS_HIGH  = `DWL_CYC(`DWL_DQS_HIGH_NS);
   localparam integer FB_WAIT   = `DWL_CYC(`DWL_FB_WAIT_NS);
   localparam integer TERM_OFF  = `DWL_CYC(`DWL_TERM_OFF_NS);
   // one-hot states
   localparam [9:0] S_IDLE  = 10'h001;
   localparam [9:0] S_ENTER = 10'h002;
   localparam [9:0] S_TERM  = 10'h004;
   localparam [9:0] S_PARK  = 10'h008;
   localparam [9:0] S_HIGH  = 10'h010;
   localparam [9:0] S_WAIT  = 10'h020;
   localparam [9:0] S_EVAL  = 10'h040;
   localparam [9:0] S_STOP  = 10'h080;
   localparam [9:0] S_EXIT  = 10'h100;
   localparam [9:0] S_HOLD  = 10'h200;

   reg  [9:0]            state;
   reg  [`DWL_CNT_W-1:0] count;
   reg  [1:0]            seenZero;
   reg  [1:0]            locked;
   wire [1:0]            fbSync;
   wire [1:0]            laneHit;
   wire [1:0]            laneDone;
   wire                  tapEnd;
   genvar                g;

   // feedback arrives asynchronously, two flops first
   dwl_sync #(
      .W (2)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .din     (dqFeedback),
      .dout    (fbSync)
   );

   assign busy = (state != S_IDLE);

   // wait needed before raising termination
   wire [`DWL_CNT_W-1:0] termWait;
   assign termWait = latRaised ? (MODE_SET[`DWL_CNT_W-1:0] + termOnLat)
                               : MODE_SET[`DWL_CNT_W-1:0];

   // per lane lock detection
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_lane
         // a 1 after an earlier 0 locks the lane
         assign laneHit[g]  = seenZero[g] & fbSync[g];
         assign laneDone[g] = locked[g] | laneHit[g];
      end
   endgenerate

   // either lane at the top tap ends the sweep
   assign tapEnd = (dqsDelayLo == `DWL_TAP_MAX) || (dqsDelayHi == `DWL_TAP_MAX);

   // leveling sequencer
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state      <= S_IDLE;
         count      <= `DWL_CNT_ZERO;
         done       <= 1'b0;
         failed     <= 1'b0;
         lockTapLo  <= `DWL_TAP_ZERO;
         lockTapHi  <= `DWL_TAP_ZERO;
         mrsValid   <= 1'b0;
         mrsData    <= 16'h0000;
         termPin    <= 1'b0;
         dqsT       <= 2'b00;
         dqsC       <= 2'b00;
         dqsOe      <= 2'b00;
         dqsDelayLo <= `DWL_TAP_ZERO;
         dqsDelayHi <= `DWL_TAP_ZERO;
         seenZero   <= 2'b00;
         locked     <= 2'b00;
      end
      else
      begin
         mrsValid <= 1'b0;
         done     <= 1'b0;
         case (state)
            // wait for a start request
            S_IDLE:
            begin
               if (start)
               begin
                  // base word must already have dynamic write termination off
                  mrsData    <= mr1Base;
                  mrsData[`DWL_MR1_LEVEL_BIT] <= 1'b1;
                  mrsValid   <= 1'b1;
                  failed     <= 1'b0;
                  dqsDelayLo <= `DWL_TAP_ZERO;
                  dqsDelayHi <= `DWL_TAP_ZERO;
                  seenZero   <= 2'b00;
                  locked     <= 2'b00;
                  count      <= `DWL_CNT_ZERO;
                  state      <= S_ENTER;
               end
            end

            // mode set delay before termination
            S_ENTER:
            begin
               // only deselects are sent while waiting
               count <= count + 8'h01;
               if (count + 8'h01 >= termWait)
               begin
                  termPin <= 1'b1;
                  count   <= `DWL_CNT_ZERO;
                  state   <= S_TERM;
               end
            end

            // strobe enable delay
            S_TERM:
            begin
               count <= count + 8'h01;
               if (count + 8'h01 >= DQS_EN[`DWL_CNT_W-1:0])
               begin
                  dqsOe <= 2'b11;
                  dqsT  <= 2'b00;
                  dqsC  <= 2'b11;
                  count <= `DWL_CNT_ZERO;
                  state <= S_PARK;
               end
            end

            // strobes parked low before a pulse
            S_PARK:
            begin
               count <= count + 8'h01;
               if ((count + 8'h01 >= DQS_LOW[`DWL_CNT_W-1:0]) &&
                   (count + 8'h01 >= FIRST_DQS[`DWL_CNT_W-1:0]))
               begin
                  dqsT  <= ~locked;
                  dqsC  <= locked;
                  count <= `DWL_CNT_ZERO;
                  state <= S_HIGH;
               end
            end

            // strobe high phase
            S_HIGH:
            begin
               count <= count + 8'h01;
               if (count + 8'h01 >= DQS_HIGH[`DWL_CNT_W-1:0])
               begin
                  dqsT  <= 2'b00;
                  dqsC  <= 2'b11;
                  count <= `DWL_CNT_ZERO;
                  state <= S_WAIT;
               end
            end

            // wait for feedback to settle
            S_WAIT:
            begin
               // covers output delay, skew and sync
               count <= count + 8'h01;
               if (count + 8'h01 >= FB_WAIT[`DWL_CNT_W-1:0])
               begin
                  count <= `DWL_CNT_ZERO;
                  state <= S_EVAL;
               end
            end

            // judge feedback and step taps
            S_EVAL:
            begin
               // lower lane
               if (!locked[0])
               begin
                  if (seenZero[0] && fbSync[0])
                  begin
                     locked[0] <= 1'b1;
                     lockTapLo <= dqsDelayLo;
                  end
                  else
                  begin
                     if (!fbSync[0])
                        seenZero[0] <= 1'b1;
                     dqsDelayLo <= dqsDelayLo + 7'h01;
                  end
               end
               // upper lane
               if (!locked[1])
               begin
                  if (seenZero[1] && fbSync[1])
                  begin
                     locked[1] <= 1'b1;
                     lockTapHi <= dqsDelayHi;
                  end
                  else
                  begin
                     if (!fbSync[1])
                        seenZero[1] <= 1'b1;
                     dqsDelayHi <= dqsDelayHi + 7'h01;
                  end
               end
               if ((laneDone == 2'b11) || tapEnd)
               begin
                  failed <= (laneDone != 2'b11);
                  state  <= S_STOP;
               end
               else
                  state <= S_PARK;
            end

            // release strobes and termination
            S_STOP:
            begin
               // strobes released and termination dropped in the same cycle
               dqsOe   <= 2'b00;
               dqsT    <= 2'b00;
               dqsC    <= 2'b00;
               termPin <= 1'b0;
               count   <= count + 8'h01;
               if (count + 8'h01 >= TERM_OFF[`DWL_CNT_W-1:0])
               begin
                  mrsData  <= mr1Base;
                  mrsData[`DWL_MR1_LEVEL_BIT] <= 1'b0;
                  mrsValid <= 1'b1;
                  count    <= `DWL_CNT_ZERO;
                  state    <= S_EXIT;
               end
            end

            // mode set delay after exit word
            S_EXIT:
            begin
               count <= count + 8'h01;
               if (count + 8'h01 >= MODE_SET[`DWL_CNT_W-1:0])
               begin
                  count <= `DWL_CNT_ZERO;
                  state <= S_HOLD;
               end
            end

            // signal completion
            S_HOLD:
            begin
               done  <= 1'b1;
               state <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule // dwl_host

// ==== rtl/dwl_consts.vh ====
`ifndef DWL_CONSTS_VH
`define DWL_CONSTS_VH
// clock period of clk_sys in picoseconds
`define DWL_CLK_PS        10000
// timings in nanoseconds
`define DWL_MODE_SET_NS   24
`define DWL_MRW_CYCLE_NS  10
`define DWL_DQS_EN_NS     40
`define DWL_FIRST_DQS_NS  40
`define DWL_DQS_LOW_NS    20
`define DWL_FB_WAIT_NS    60
`define DWL_DQS_HIGH_NS   20
`define DWL_TERM_OFF_NS   20
// derived cycle counts (least times round up)
`define DWL_CYC(ns) (((ns) * 1000 + `DWL_CLK_PS - 1) / `DWL_CLK_PS)
// mode register one bit positions
`define DWL_MR1_LEVEL_BIT 7
`define DWL_MR1_QOFF_BIT  12
// delay tap range
`define DWL_TAP_W         7
`define DWL_TAP_MAX       7'h7f
`define DWL_TAP_ZERO      7'h00
`define DWL_CNT_W         8
`define DWL_CNT_ZERO      8'h00
`endif

// ==== rtl/dwl_sync.v ====
`timescale 1ns/1ps
// two flop synchroniser, one per bit
module dwl_sync #(
   parameter W = 2
) (
   // clock and reset
   input  wire         clk_sys,
   input  wire         rst_n,
   // data
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   genvar i;
   // each bit passes two flops
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
            end
            else
            begin
               stage1[i] <= din[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate
   assign dout = stage2;
endmodule // dwl_sync

// ==== testbench/dwl_host_sva.sv ====
`timescale 1ns/1ps
`include "dwl_consts.vh"
module dwl_host_chk (
   // clock and reset
   input wire                  clk_sys,
   input wire                  rst_n,
   // user side
   input wire                  start,
   input wire [15:0]           mr1Base,
   input wire                  busy,
   input wire                  done,
   // device side
   input wire                  mrsValid,
   input wire [15:0]           mrsData,
   input wire                  termPin,
   input wire [1:0]            dqsT,
   input wire [1:0]            dqsC,
   input wire [1:0]            dqsOe,
   input wire [`DWL_TAP_W-1:0] dqsDelayLo
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_entry_word: assert property (start && !busy |=> mrsValid && mrsData[7])
      else $error("entry word missing");
   a_other_bits: assert property (mrsValid |-> (mrsData & 16'hef7f) == (mr1Base & 16'hef7f))
      else $error("mode word bits altered");
   a_term_wait: assert property (mrsValid && mrsData[7] |-> !termPin [*3])
      else $error("termination raised early");
   a_dqs_enable: assert property ($rose(dqsOe[0]) |-> $past(termPin, 4) && dqsOe == 2'b11
      && dqsT == 2'b00 && dqsC == 2'b11) else $error("strobe enable wrong");
   a_first_pulse: assert property ($rose(dqsOe[0]) |-> !dqsT[0] [*4] ##1 dqsT[0])
      else $error("first pulse timing");
   a_pulse_width: assert property ($rose(dqsT[0]) |-> dqsT[0] [*2] ##1 !dqsT[0])
      else $error("pulse width");
   a_strobe_pair: assert property (dqsOe[0] |-> dqsC[0] == !dqsT[0])
      else $error("strobe pair not complementary");
   a_tap_step: assert property (dqsOe[0] && $changed(dqsDelayLo)
      |-> dqsDelayLo == $past(dqsDelayLo) + 7'h01) else $error("tap step");
   a_exit_order: assert property (mrsValid && !mrsData[7] |-> dqsOe == 2'b00 && !termPin
      && !$past(termPin)) else $error("exit order");
   a_done_gap: assert property (mrsValid && !mrsData[7] |=> !done [*2] ##[1:2] done)
      else $error("done timing");
   c_exit: cover property (mrsValid && !mrsData[7]);
   c_upper: cover property ($rose(dqsT[1]));
   c_done: cover property (done);
endmodule // dwl_host_chk
bind dwl_host dwl_host_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
   .mr1Base(mr1Base), .busy(busy), .done(done), .mrsValid(mrsValid), .mrsData(mrsData),
   .termPin(termPin), .dqsT(dqsT), .dqsC(dqsC), .dqsOe(dqsOe), .dqsDelayLo(dqsDelayLo));

// ==== testbench/dwl_dev_model.sv ====
`timescale 1ns/1ps
module dwl_dev_model #(
   parameter real TAP_NS  = 1.0,
   parameter real WLO_NS  = 9.0,
   parameter real SKEW_NS = 2.0,
   parameter real CK_NS   = 80.0
) (
   // link clock and host pins
   input  wire        ckLink,
   input  wire        mrsValid,
   input  wire [15:0] mrsData,
   input  wire        termPin,
   input  wire [1:0]  dqsT,
   input  wire [1:0]  dqsOe,
   input  wire [6:0]  dqsDelayLo,
   input  wire [6:0]  dqsDelayHi,
   input  wire        stuckLow,
   // feedback only, no read strobe returned
   output wire [1:0]  dqFeedback
);
   logic [15:0] modeRegOne = 16'h0000;
   logic [1:0]  fbVal = 2'b00, fbOk = 2'b00, junk = 2'b01;
   logic [7:0]  hist0[$], hist1[$];
   realtime     tRise = 0;
   wire  [1:0]  strobeTerm, drv;
   // clock edge time and undefined line pattern
   always @(posedge ckLink)
   begin
      tRise = $realtime;
      junk = ~junk;
   end
   // mode word, exit also applies the other bits
   always @(posedge mrsValid)
   begin
      #1;
      modeRegOne = mrsData;
      fbOk = 2'b00;
      if (mrsData[7]) hist0.delete();
      if (mrsData[7]) hist1.delete();
   end
   // strobe termination only, 1 nominal 2 park
   assign strobeTerm = !modeRegOne[7] ? 2'h0 : (termPin ? 2'h1 : 2'h2);
   function automatic logic ckAt(input realtime d);
      realtime p;
      p = $realtime + d - tRise;
      p = p - CK_NS * $floor(p / CK_NS);
      return p < CK_NS / 2.0;
   endfunction
   // sample clock at the delayed strobe edge, answer per lane
   task automatic sample(input int l, input logic [6:0] tap);
      logic v;
      v = !stuckLow && ckAt(tap * TAP_NS - 1.0);
      if (l == 0) hist0.push_back({v, tap});
      else hist1.push_back({v, tap});
      fbVal[l] <= #(WLO_NS + l * SKEW_NS) v;
      fbOk[l] <= #(WLO_NS + l * SKEW_NS) 1'b1;
   endtask
   always @(posedge dqsT[0])
   begin
      #1;
      if (modeRegOne[7] && dqsOe[0]) sample(0, dqsDelayLo);
   end
   always @(posedge dqsT[1])
   begin
      #1;
      if (modeRegOne[7] && dqsOe[1]) sample(1, dqsDelayHi);
   end
   always @(negedge dqsOe[0]) fbOk[0] = 1'b0;
   always @(negedge dqsOe[1]) fbOk[1] = 1'b0;
   // output off or undefined gives a changing pattern
   assign drv = fbOk & ~{2{modeRegOne[12]}} & {2{modeRegOne[7]}};
   assign dqFeedback = (drv & fbVal) | (~drv & junk);
endmodule // dwl_dev_model

// ==== testbench/dwl_host_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module dwl_host_tb_top;
   logic        clk_sys = 1'b0;
   logic        ckLink = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   logic [15:0] mr1Base = 16'h0000;
   logic        latRaised = 1'b0;
   logic [7:0]  termOnLat = 8'h00;
   logic        stuckLow = 1'b0;
   wire         busy, done, failed, mrsValid, termPin;
   wire  [6:0]  lockTapLo, lockTapHi, dqsDelayLo, dqsDelayHi;
   wire  [15:0] mrsData;
   wire  [1:0]  dqsT, dqsC, dqsOe, dqFeedback;
   logic [15:0] mrsQ[$];
   logic [7:0]  gapCnt = 8'h00, termGap = 8'h00;
   logic        termPrev = 1'b0;
   int          failures = 0, n_tests = 0, i;
   // system and link clocks
   always #5 clk_sys = ~clk_sys;
   always #40 ckLink = ~ckLink;
   dwl_host DUT (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .mr1Base(mr1Base),
      .latRaised(latRaised), .termOnLat(termOnLat), .busy(busy), .done(done), .failed(failed),
      .lockTapLo(lockTapLo), .lockTapHi(lockTapHi), .mrsValid(mrsValid), .mrsData(mrsData),
      .termPin(termPin), .dqsT(dqsT), .dqsC(dqsC), .dqsOe(dqsOe), .dqsDelayLo(dqsDelayLo),
      .dqsDelayHi(dqsDelayHi), .dqFeedback(dqFeedback));
   dwl_dev_model dev (.ckLink(ckLink), .mrsValid(mrsValid), .mrsData(mrsData),
      .termPin(termPin), .dqsT(dqsT), .dqsOe(dqsOe), .dqsDelayLo(dqsDelayLo),
      .dqsDelayHi(dqsDelayHi), .stuckLow(stuckLow), .dqFeedback(dqFeedback));
   // mode words and entry to termination gap
   always @(posedge clk_sys)
   begin
      if (mrsValid) mrsQ.push_back(mrsData);
      gapCnt <= (mrsValid && mrsData[7]) ? 8'h00 : gapCnt + 8'h01;
      if (termPin && !termPrev) termGap <= gapCnt + 8'h01;
      termPrev <= termPin;
   end
   // lock tap from first 1 after a 0, bit7 set when none
   function automatic logic [7:0] expLock(input logic [7:0] h[$]);
      logic seen0;
      seen0 = 1'b0;
      foreach (h[k])
      begin
         if (h[k][7] && seen0) return {1'b0, h[k][6:0]};
         if (!h[k][7]) seen0 = 1'b1;
      end
      return 8'h80;
   endfunction
   task report_and_stop;
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one leveling run with a refused start in the middle
   task automatic run(input logic [15:0] base, input logic lat, input logic [7:0] tol,
                      input logic stuck);
      logic [7:0] e0, e1;
      int k;
      mrsQ.delete();
      @(posedge clk_sys);
      mr1Base <= base;
      latRaised <= lat;
      termOnLat <= tol;
      stuckLow <= stuck;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (9) @(posedge clk_sys);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 5000)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (k >= 5000) failures++;
      if (k >= 5000) report_and_stop();
      e0 = expLock(dev.hist0);
      e1 = expLock(dev.hist1);
      if (!base[12]) `CHK(failed, e0[7] | e1[7])
      if (!base[12] && !(e0[7] | e1[7])) `CHK({lockTapHi, lockTapLo}, {e1[6:0], e0[6:0]})
      `CHK(mrsQ.size(), 2)
      `CHK(mrsQ[0], base | 16'h0080)
      `CHK(mrsQ[1], base & 16'hff7f)
      `CHK(termGap, 8'h03 + (lat ? tol : 8'h00))
      `CHK({termPin, dqsOe}, 3'h0)
      `CHK(busy, 1'b0)
   endtask
   initial
   begin
      void'($urandom(32'h34be));
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++) run(16'($urandom) & 16'hefff, i[0], 8'($urandom_range(12)), 1'b0);
      run(16'($urandom) | 16'h1000, 1'b0, 8'h00, 1'b0);
      run(16'($urandom) & 16'hefff, 1'b1, 8'h00, 1'b1);
      // reset in mid run, then a clean run
      @(posedge clk_sys);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK({busy, termPin, dqsOe, mrsValid, done}, 6'h00)
      @(posedge clk_sys);
      rst_n <= 1'b1;
      run(16'($urandom) & 16'hefff, 1'b0, 8'h00, 1'b0);
      report_and_stop();
   end
endmodule // dwl_host_tb_top
